/* logic/i2csas_pkg.sv */
// Package for the slave access status block: offsets, bit positions, resets, types.
// Assumes big-endian bit numbering of the register maps to little-endian bit index here.
package i2csas_pkg;
  localparam logic [19:0] STATUS_OFFSET = 20'h1d220;
  localparam logic [7:0] PERIPH_STATUS_FIRST = 8'h20;
  localparam logic [7:0] PERIPH_STATUS_LAST = 8'h23;
  // Documented bit 0 is the MSB of the word, bit 31 the LSB
  localparam int ACCESS_SUCCESS_FLAG_DOC_BIT = 24;
  localparam int OUT_DOC_BIT = 28;
  localparam int IN_DOC_BIT = 29;
  localparam int ALERT_DOC_BIT = 31;
  localparam int ACCESS_SUCCESS_FLAG_POS = 31 - ACCESS_SUCCESS_FLAG_DOC_BIT;
  localparam int OUT_POS = 31 - OUT_DOC_BIT;
  localparam int IN_POS = 31 - IN_DOC_BIT;
  localparam int ALERT_POS = 31 - ALERT_DOC_BIT;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic LINK_SYNC_RESET = 1'b1;

  // Slave-port events from the I2C slave engine, one-cycle pulses on clk
  typedef struct packed {
    logic access_done;
    logic access_ok;
    logic status_read;
    logic [7:0] periph_addr;
    logic out_box_read;
    logic in_box_write;
    logic ara_ack;
  } i2csas_slave_ev_t;

  // Local software events, one-cycle pulses on clk
  typedef struct packed {
    logic out_box_write;
    logic in_box_read;
    logic status_read;
    logic indirect_read;
  } i2csas_local_ev_t;

  typedef enum logic [1:0] {
    I2CSAS_IDLE = 2'b00,
    I2CSAS_BUSY = 2'b01,
    I2CSAS_STOP = 2'b11
  } i2csas_xfer_t;
endpackage : i2csas_pkg

/* logic/i2csas_status.sv */
// Slave access status register with mailbox flags and alert flag.
// Assumes event pulses on clk; scl/sda come from pins and are synchronised here.
`timescale 1ns/10ps
module i2csas_status
  import i2csas_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic i2c_block_resetn,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire i2csas_pkg::i2csas_slave_ev_t slave_ev,
  input wire i2csas_pkg::i2csas_local_ev_t local_ev,
  input wire logic alert_required,
  input wire logic hard_reset_status,
  output logic [31:0] slave_access_status,
  output logic outbound_box_drained_irq,
  output logic inbound_box_filled_irq,
  output logic alert_active
);
  import i2csas_pkg::*;

  // Link pins in vector order: scl first, then sda
  localparam int LINK_PINS = 2;
  localparam int SCL_IDX = 0;
  localparam int SDA_IDX = 1;

  wire logic [LINK_PINS-1:0] link_pin = {sda_pin, scl_pin};
  logic [LINK_PINS-1:0] link_meta;
  logic [LINK_PINS-1:0] link_sync;
  logic [LINK_PINS-1:0] link_prev;

  i2csas_xfer_t xfer_state;
  i2csas_xfer_t next_xfer_state;

  logic access_success_flag;
  logic next_access_success_flag;
  logic outbound_box_pending;
  logic next_outbound_box_pending;
  logic inbound_box_pending;
  logic next_inbound_box_pending;
  logic alert_flag;
  logic next_alert_flag;
  logic out_read_seen;
  logic next_out_read_seen;
  logic in_write_seen;
  logic next_in_write_seen;
  logic drained_pulse;
  logic next_drained_pulse;
  logic filled_pulse;
  logic next_filled_pulse;
  logic [31:0] next_slave_access_status;

  wire logic clr_all = !resetn || !i2c_block_resetn;
  wire logic scl_now = link_sync[SCL_IDX];
  wire logic sda_now = link_sync[SDA_IDX];
  wire logic scl_was = link_prev[SCL_IDX];
  wire logic sda_was = link_prev[SDA_IDX];
  // Edges judged on synchronised samples only
  wire logic stop_cond = scl_now && scl_was && sda_now && !sda_was;
  wire logic start_cond = scl_now && scl_was && !sda_now && sda_was;
  wire logic status_lsb_read = slave_ev.status_read
    && (slave_ev.periph_addr == PERIPH_STATUS_FIRST);
  wire logic set_ok = slave_ev.access_done && slave_ev.access_ok;
  wire logic xfer_end = (xfer_state == I2CSAS_BUSY) && stop_cond;
  wire logic out_read_any = out_read_seen || slave_ev.out_box_read;
  wire logic in_write_any = in_write_seen || slave_ev.in_box_write;
  wire logic out_drain = xfer_end && out_read_any;
  wire logic in_fill = xfer_end && in_write_any;
  wire logic alert_set = alert_required || hard_reset_status;
  wire logic alert_clear = slave_ev.ara_ack || !alert_set;

  // Two flops per pin, a third for edge detection
  genvar g;
  generate
    for (g = 0; g < LINK_PINS; g++)
    begin : g_link_sync
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          link_meta[g] <= LINK_SYNC_RESET;
          link_sync[g] <= LINK_SYNC_RESET;
          link_prev[g] <= LINK_SYNC_RESET;
        end
        else
        begin
          link_meta[g] <= link_pin[g];
          link_sync[g] <= link_meta[g];
          link_prev[g] <= link_sync[g];
        end
      end
    end
  endgenerate

  always_comb
  begin
    next_xfer_state = xfer_state;
    case (xfer_state)
      I2CSAS_IDLE: if (start_cond) next_xfer_state = I2CSAS_BUSY;
      I2CSAS_BUSY: if (stop_cond) next_xfer_state = I2CSAS_STOP;
      I2CSAS_STOP: next_xfer_state = start_cond ? I2CSAS_BUSY : I2CSAS_IDLE;
      default: next_xfer_state = I2CSAS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      xfer_state <= I2CSAS_IDLE;
    end
    else
    begin
      xfer_state <= next_xfer_state;
    end
  end

  // Set wins over the slave-port clear; local and indirect reads never reach here
  always_comb
  begin
    next_access_success_flag = access_success_flag;
    if (set_ok)
      next_access_success_flag = 1'b1;
    else if (status_lsb_read)
      next_access_success_flag = 1'b0;
  end

  // Box events are held until the STOP that ends the transaction
  always_comb
  begin
    next_out_read_seen = out_read_any;
    next_in_write_seen = in_write_any;
    if (xfer_end)
    begin
      next_out_read_seen = 1'b0;
      next_in_write_seen = 1'b0;
    end
  end

  // A software write in the drain cycle keeps the box pending and drops the pulse
  always_comb
  begin
    next_outbound_box_pending = outbound_box_pending;
    next_drained_pulse = out_drain && outbound_box_pending
      && !local_ev.out_box_write;
    if (local_ev.out_box_write)
      next_outbound_box_pending = 1'b1;
    else if (out_drain)
      next_outbound_box_pending = 1'b0;
  end

  // A master fill beats a software read in the same cycle
  always_comb
  begin
    next_inbound_box_pending = inbound_box_pending;
    next_filled_pulse = in_fill;
    if (in_fill)
      next_inbound_box_pending = 1'b1;
    else if (local_ev.in_box_read)
      next_inbound_box_pending = 1'b0;
  end

  // Alert address reply wins over a still-pending alert request
  always_comb
  begin
    next_alert_flag = alert_flag;
    if (slave_ev.ara_ack)
      next_alert_flag = 1'b0;
    else if (alert_set)
      next_alert_flag = 1'b1;
    else if (alert_clear)
      next_alert_flag = 1'b0;
  end

  // Read-only word; no write path exists, reserved bits stay zero
  always_comb
  begin
    next_slave_access_status = STATUS_RESET;
    next_slave_access_status[ACCESS_SUCCESS_FLAG_POS] = access_success_flag;
    next_slave_access_status[OUT_POS] = outbound_box_pending;
    next_slave_access_status[IN_POS] = inbound_box_pending;
    next_slave_access_status[ALERT_POS] = alert_flag;
  end

  // State registers; either reset clears them all
  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      access_success_flag <= 1'b0;
    end
    else
    begin
      access_success_flag <= next_access_success_flag;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      out_read_seen <= 1'b0;
    end
    else
    begin
      out_read_seen <= next_out_read_seen;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      in_write_seen <= 1'b0;
    end
    else
    begin
      in_write_seen <= next_in_write_seen;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      outbound_box_pending <= 1'b0;
    end
    else
    begin
      outbound_box_pending <= next_outbound_box_pending;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      drained_pulse <= 1'b0;
    end
    else
    begin
      drained_pulse <= next_drained_pulse;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      inbound_box_pending <= 1'b0;
    end
    else
    begin
      inbound_box_pending <= next_inbound_box_pending;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      filled_pulse <= 1'b0;
    end
    else
    begin
      filled_pulse <= next_filled_pulse;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      alert_flag <= 1'b0;
    end
    else
    begin
      alert_flag <= next_alert_flag;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clr_all)
    begin
      slave_access_status <= STATUS_RESET;
    end
    else
    begin
      slave_access_status <= next_slave_access_status;
    end
  end

  assign outbound_box_drained_irq = drained_pulse;
  assign inbound_box_filled_irq = filled_pulse && inbound_box_pending;
  assign alert_active = alert_flag;
endmodule : i2csas_status

/* tb/i2csas_master.sv */
// I2C master model: START, nine link clocks, STOP.
// Assumes pulled-up lines, so idle reads high.
`timescale 1ns/10ps
module i2csas_master (
  output logic scl_pin,
  output logic sda_pin
);
  initial {scl_pin, sda_pin} = 2'b11;
  task automatic start_cond;
    sda_pin = 1'b0;
    #80 scl_pin = 1'b0;
    repeat (18) #80 scl_pin = ~scl_pin;
    #80 scl_pin = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    #80 sda_pin = 1'b0;
    #80 scl_pin = 1'b1;
    #80 sda_pin = 1'b1;
  endtask : stop_cond
endmodule : i2csas_master

/* tb/i2csas_status_sva.sv */
// Checker for the slave access status block.
// Assumes it is bound into the block and sees its ports only.
`timescale 1ns/10ps
module i2csas_status_sva
  import i2csas_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic i2c_block_resetn,
  input wire i2csas_pkg::i2csas_slave_ev_t slave_ev,
  input wire i2csas_pkg::i2csas_local_ev_t local_ev,
  input wire logic alert_required,
  input wire logic hard_reset_status,
  input wire logic [31:0] slave_access_status,
  input wire logic outbound_box_drained_irq,
  input wire logic alert_active
);
  wire logic [31:0] s = slave_access_status;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || !i2c_block_resetn);
  sequence slave_rd;
    slave_ev.status_read && slave_ev.periph_addr == PERIPH_STATUS_FIRST && !slave_ev.access_done;
  endsequence
  reserved_zero_a: assert property ((s & ~32'h8d) == 32'h0)
    else $error("reserved set");
  block_clear_a: assert property (disable iff (!resetn)
    !i2c_block_resetn |=> s == 32'h0) else $error("no block clear");
  acc_clr_a: assert property (slave_rd |-> ##2 !s[ACCESS_SUCCESS_FLAG_POS])
    else $error("ok not cleared");
  out_set_a: assert property (local_ev.out_box_write |-> ##2 s[OUT_POS])
    else $error("out not set");
  drained_a: assert property ($fell(s[OUT_POS]) |-> $past(outbound_box_drained_irq))
    else $error("no drained");
  in_fall_a: assert property ($fell(s[IN_POS]) |-> $past(local_ev.in_box_read, 2))
    else $error("in cleared");
  alert_set_a: assert property ((alert_required || hard_reset_status)
    && !slave_ev.ara_ack |=> alert_active) else $error("no alert");
  alert_clr_a: assert property (!alert_required && !hard_reset_status |=> !alert_active)
    else $error("alert stuck");
endmodule : i2csas_status_sva
bind i2csas_status i2csas_status_sva i2csas_status_sva_inst (.*);

/* tb/i2csas_status_test.sv */
// Bench for the slave access status block.
// Assumes the master model makes pin frames; events are one-cycle pulses.
`timescale 1ns/10ps
module i2csas_status_test;
  import i2csas_pkg::*;
  logic clk, resetn, i2c_block_resetn, scl_pin, sda_pin, alert_required, hard_reset_status, ok;
  logic outbound_box_drained_irq, inbound_box_filled_irq, alert_active;
  logic [31:0] slave_access_status;
  i2csas_slave_ev_t slave_ev;
  i2csas_local_ev_t local_ev;
  int errors, n_tests, n_dr, n_fi;
  wire logic [31:0] st = slave_access_status;
  wire logic [31:0] sa = {st[31:1], st[0] & alert_active};
  i2csas_status i2csas_status_inst (.*);
  i2csas_master i2csas_master_inst (.*);
  function automatic logic [31:0] word(input logic a, o, i, l);
    word = 32'h0;
    {word[ACCESS_SUCCESS_FLAG_POS], word[OUT_POS], word[IN_POS], word[ALERT_POS]} = {a, o, i, l};
  endfunction : word
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_dr += int'(outbound_box_drained_irq === 1'b1);
    n_fi += int'(inbound_box_filled_irq === 1'b1);
  end
  initial
  begin
    #100000;
    errors++;
    complete_run();
  end
  initial
  begin
    {resetn, i2c_block_resetn, alert_required, hard_reset_status} = 4'h0;
    slave_ev = '0;
    local_ev = '0;
    void'($urandom(32'hc1b98f50));
    tick(10);
    {resetn, i2c_block_resetn} = 2'b11;
    tick(1);
    check("reset", st, 32'h0);
    repeat (20)
    begin
      ok = 1'($urandom);
      slave_ev.access_done = 1'b1;
      slave_ev.access_ok = ok;
      tick(1);
      slave_ev = '0;
      local_ev.status_read = 1'($urandom);
      local_ev.indirect_read = 1'($urandom);
      tick(1);
      local_ev = '0;
      tick(2);
      check("acc_keep", st, word(ok, 0, 0, 0));
      slave_ev.status_read = 1'b1;
      slave_ev.periph_addr = PERIPH_STATUS_FIRST;
      tick(1);
      slave_ev = '0;
      tick(2);
      check("acc_clear", st, 32'h0);
    end
    local_ev.out_box_write = 1'b1;
    tick(1);
    local_ev = '0;
    tick(2);
    check("out_set", st, word(0, 1, 0, 0));
    i2csas_master_inst.start_cond();
    tick(1);
    slave_ev.out_box_read = 1'b1;
    slave_ev.in_box_write = 1'b1;
    tick(1);
    slave_ev = '0;
    tick(3);
    check("pre_stop", st, word(0, 1, 0, 0));
    i2csas_master_inst.stop_cond();
    tick(8);
    check("post_stop", st, word(0, 0, 1, 0));
    check("irqs", {30'h0, n_dr != 0, n_fi != 0}, 32'h3);
    local_ev.in_box_read = 1'b1;
    tick(1);
    local_ev = '0;
    tick(2);
    check("in_clear", st, 32'h0);
    for (int k = 1; k < 3; k++)
    begin
      {alert_required, hard_reset_status} = 2'(k);
      tick(3);
      check("alert_set", sa, word(0, 0, 0, 1));
      slave_ev.ara_ack = (k == 2);
      {alert_required, hard_reset_status} = 2'b00;
      tick(1);
      slave_ev = '0;
      tick(2);
      check("alert_clear", {st[31:1], st[0] | alert_active}, 32'h0);
    end
    local_ev.out_box_write = 1'b1;
    tick(1);
    local_ev = '0;
    i2c_block_resetn = 1'b0;
    tick(2);
    check("block_reset", st, 32'h0);
    complete_run();
  end
endmodule : i2csas_status_test
